// file: inc/pmt_defines.svh
// Functional notes
// - count clock is instruction clock through prescaler
// - input divider select: 1, 4 or 16
// - count and period are eight bits
// - count rises from zero, compared with period
// - on match count reloads zero next increment
// - matches feed postscaler which sets match flag
// - count and period fully readable and writable
// - reset clears count, period goes all ones
// - run enable bit starts and stops counting
// - dividers cleared by count/control write, reset
// - control write leaves count unchanged
// - control bit seven reads zero, resets zero
// - flag and enable at bit one, reset zero
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

// =====================================================
// register offsets
`define PMT_ADDR_CTRL      4'h0
`define PMT_ADDR_COUNT     4'h1
`define PMT_ADDR_PERIOD    4'h2
`define PMT_ADDR_FLAG      4'h3
`define PMT_ADDR_ENABLE    4'h4

// =====================================================
// field positions and reset values
`define PMT_CTRL_MASK      8'h7f
`define PMT_RUN_BIT        2
`define PMT_PRE_LO         0
`define PMT_PRE_HI         1
`define PMT_POST_LO        3
`define PMT_POST_HI        6
`define PMT_IRQ_BIT        1
`define PMT_IRQ_MASK       8'h02
`define PMT_CTRL_RST       8'h00
`define PMT_COUNT_RST      8'h00
`define PMT_PERIOD_RST     8'hff
`define PMT_FLAG_RST       8'h00
`define PMT_ENABLE_RST     8'h00

// =====================================================
// timing: oscillator cycles per instruction cycle
`define PMT_OSC_PER_INSTR  4
`define PMT_PRE_DIV4       4'h3
`define PMT_PRE_DIV16      4'hf

`endif

// file: inc/pmt_pkg.sv
package pmt_pkg;
  typedef logic [7:0] pmt_byte_t;
  typedef enum logic [1:0] {
    PMT_PRE_1,
    PMT_PRE_4,
    PMT_PRE_16
  } pmt_pre_e;
endpackage : pmt_pkg

// file: design/pmt_div.sv
`timescale 1ns/100ps
// =====================================================
// divide counter: pulses done_q every (limit + 1) ticks
module pmt_div #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // control
  input  wire logic             clear,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] limit,
  // result
  output logic                  done_q
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             done_d;

  initial begin
    if (WIDTH < 1) $error("pmt_div width must be at least one");
  end

  // count ticks, wrap at limit; clear wins over tick
  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (clear) begin
      cnt_d = '0;
    end else if (tick) begin
      if (cnt_q >= limit) begin
        cnt_d  = '0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end
endmodule : pmt_div

// file: design/pmt_timer.sv
`timescale 1ns/100ps
`include "pmt_defines.svh"
// =====================================================
// eight-bit period match timer with postscaled interrupt
module pmt_timer #(
  parameter int OSC_PER_INSTR = `PMT_OSC_PER_INSTR
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_q,
  // interrupt and match
  output logic            irq_q,
  output logic            match_q
);
  logic [7:0] ctrl_q, ctrl_d, count_q, count_d, period_q, period_d;
  logic [7:0] flag_q, flag_d, enable_q, enable_d, rdata_d;
  logic [1:0] instr_q, instr_d;
  logic       instr_tick, run, div_clear, pre_done, post_done, inc_tick, is_match;
  logic       irq_d, match_d;
  logic [3:0] pre_limit;
  pmt_pkg::pmt_pre_e pre_sel;

  initial begin
    if (OSC_PER_INSTR < 1 || OSC_PER_INSTR > 4) $error("OSC_PER_INSTR out of range");
  end

  // =====================================================
  // instruction clock enable: one pulse per OSC_PER_INSTR ref clocks
  always_comb begin
    instr_d    = instr_q + 2'h1;
    instr_tick = (instr_q == 2'(OSC_PER_INSTR - 1));
    if (instr_tick) instr_d = 2'h0;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) instr_q <= 2'h0;
    else instr_q <= instr_d;
  end

  // =====================================================
  // prescale select decode; 1x means sixteen
  always_comb begin
    run = ctrl_q[`PMT_RUN_BIT];
    if (ctrl_q[`PMT_PRE_HI]) pre_sel = pmt_pkg::PMT_PRE_16;
    else if (ctrl_q[`PMT_PRE_LO]) pre_sel = pmt_pkg::PMT_PRE_4;
    else pre_sel = pmt_pkg::PMT_PRE_1;
    unique case (pre_sel)
      pmt_pkg::PMT_PRE_1:  pre_limit = 4'h0;
      pmt_pkg::PMT_PRE_4:  pre_limit = `PMT_PRE_DIV4;
      pmt_pkg::PMT_PRE_16: pre_limit = `PMT_PRE_DIV16;
      default:             pre_limit = 4'h0;
    endcase
    // any write to count or control restarts both dividers
    div_clear = reg_wr && (reg_addr == `PMT_ADDR_COUNT || reg_addr == `PMT_ADDR_CTRL);
    is_match  = (count_q == period_q);
  end

  // prescaler: frozen while stopped
  pmt_div #(.WIDTH(4)) u_pre (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clear   (div_clear),
    .tick    (instr_tick && run),
    .limit   (pre_limit),
    .done_q  (pre_done)
  );

  // postscaler: advanced once per match increment
  pmt_div #(.WIDTH(4)) u_post (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clear   (div_clear),
    .tick    (inc_tick && is_match && !div_clear),
    .limit   (ctrl_q[`PMT_POST_HI:`PMT_POST_LO]),
    .done_q  (post_done)
  );

  // =====================================================
  // registers, counter and flags
  always_comb begin
    // pre_done is one cycle late; gate on run so a stop takes effect at once
    inc_tick = pre_done && run && !div_clear;
    ctrl_d   = ctrl_q;
    count_d  = count_q;
    period_d = period_q;
    flag_d   = flag_q;
    enable_d = enable_q;
    match_d  = 1'b0;
    if (inc_tick) begin
      match_d = is_match;
      count_d = is_match ? 8'h00 : count_q + 8'h01;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `PMT_ADDR_CTRL:   ctrl_d   = reg_wdata & `PMT_CTRL_MASK;
        `PMT_ADDR_COUNT:  count_d  = reg_wdata;
        `PMT_ADDR_PERIOD: period_d = reg_wdata;
        `PMT_ADDR_FLAG:   flag_d   = reg_wdata & `PMT_IRQ_MASK;
        `PMT_ADDR_ENABLE: enable_d = reg_wdata & `PMT_IRQ_MASK;
        default:          ;
      endcase
    end
    // reading the flag register clears it
    if (reg_rd && reg_addr == `PMT_ADDR_FLAG) flag_d = 8'h00;
    // hardware set wins over any clear in the same cycle
    if (post_done) flag_d[`PMT_IRQ_BIT] = 1'b1;
    irq_d = |(flag_d & enable_d);
    unique case (reg_addr)
      `PMT_ADDR_CTRL:   rdata_d = ctrl_q & `PMT_CTRL_MASK;
      `PMT_ADDR_COUNT:  rdata_d = count_q;
      `PMT_ADDR_PERIOD: rdata_d = period_q;
      `PMT_ADDR_FLAG:   rdata_d = flag_q;
      `PMT_ADDR_ENABLE: rdata_d = enable_q;
      default:          rdata_d = 8'h00; // unmapped reads zero
    endcase
    if (!reg_rd) rdata_d = 8'h00;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q      <= `PMT_CTRL_RST;
      count_q     <= `PMT_COUNT_RST;
      period_q    <= `PMT_PERIOD_RST;
      flag_q      <= `PMT_FLAG_RST;
      enable_q    <= `PMT_ENABLE_RST;
      reg_rdata_q <= 8'h00;
      irq_q       <= 1'b0;
      match_q     <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      count_q     <= count_d;
      period_q    <= period_d;
      flag_q      <= flag_d;
      enable_q    <= enable_d;
      reg_rdata_q <= rdata_d;
      irq_q       <= irq_d;
      match_q     <= match_d;
    end
  end
endmodule : pmt_timer

// file: tb/pmt_timer_properties.sv
`timescale 1ns/100ps
// =====================================================
// port checks of the period match timer
module pmt_timer_properties #(
  parameter int OSC_PER_INSTR = 4
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // register port and outputs
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       irq_q,
  input wire logic       match_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // read path: data only after a strobe, dead bits stay low
  a_rd_idle: assert property (
    !$past(reg_rd) |-> reg_rdata_q == 8'h00) else $error("stray read data");
  a_ctrl_top: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h0 |-> !reg_rdata_q[7]) else $error("ctrl bit7 set");
  a_flag_bits: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h3 |-> (reg_rdata_q & 8'hfd) == 8'h00)
    else $error("flag spare bits set");
  // write then read back, one idle cycle between
  a_per_wr: assert property (
    reg_wr && reg_addr == 4'h2 ##2 reg_rd && reg_addr == 4'h2 |=>
    reg_rdata_q == $past(reg_wdata, 3)) else $error("period readback");
  a_cnt_wr: assert property (
    reg_wr && reg_addr == 4'h1 ##2 reg_rd && reg_addr == 4'h1 |=>
    reg_rdata_q == $past(reg_wdata, 3)) else $error("count readback");
  // an increment needs at least one full instruction cycle
  a_match_gap: assert property (
    match_q |=> !match_q [*3]) else $error("matches too close");
  a_rst_quiet: assert property (
    $fell(reset) |-> !irq_q && !match_q && reg_rdata_q == 8'h00) else $error("dirty reset");
  a_irq_off: assert property (
    reg_wr && reg_addr == 4'h4 && !reg_wdata[1] |-> ##2 !irq_q) else $error("masked irq");
endmodule : pmt_timer_properties

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  // =====================================================
  // signals
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata_q;
  logic       irq_q;
  logic       match_q;
  int         fails = 0;
  int         check_count = 0;
  int         cycles = 0;
  // clock, 100 ns
  initial forever #50 ref_clk = ~ref_clk;
  pmt_timer #(.OSC_PER_INSTR(4)) DUT (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .irq_q(irq_q), .match_q(match_q));
  // =====================================================
  // shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(n, {8'h00, e}, {8'h00, reg_rdata_q});
  endtask : rdc
  // edges until the next match pulse, bounded
  task automatic wt(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (match_q !== 1'b1 && n < 4000);
  endtask : wt
  // =====================================================
  // scenarios
  task automatic t_regs();
    rdc("ctrl", 4'h0, 8'h00);
    rdc("count", 4'h1, 8'h00);
    rdc("period", 4'h2, 8'hff);
    rdc("flag", 4'h3, 8'h00);
    rdc("enable", 4'h4, 8'h00);
    wr(4'h0, 8'hfb);
    rdc("ctrl", 4'h0, 8'h7b);
    wr(4'h2, 8'ha5);
    rdc("period", 4'h2, 8'ha5);
    wr(4'h1, 8'h5a);
    rdc("count", 4'h1, 8'h5a);
    wr(4'h5, 8'hff);
    rdc("unmapped", 4'h5, 8'h00);
  endtask : t_regs
  // first wait may catch a pulse from the old setting, so the third gap is judged
  task automatic t_pre();
    int n;
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, {5'h00, 1'b1, c[1:0]});
      repeat (3) wt(n);
      chk("match gap", 16'(12 * (c == 0 ? 1 : c == 1 ? 4 : 16)), 16'(n));
    end
  endtask : t_pre
  task automatic t_post();
    int n;
    for (int p = 0; p < 16; p += 5) begin
      wr(4'h0, 8'h00);
      wr(4'h4, 8'h02);
      rdc("flag", 4'h3, 8'h02);
      wr(4'h0, {1'b0, p[3:0], 3'h4});
      n = 0;
      for (int k = 0; k < 3000 && irq_q !== 1'b1; k++) begin
        @(posedge ref_clk);
        n += int'(match_q === 1'b1);
      end
      chk("post count", 16'(p + 1), 16'(n));
    end
    rdc("flag", 4'h3, 8'h02);
    #200 chk("irq clear", 16'h0000, {15'h0000, irq_q});
    wr(4'h4, 8'h00);
    repeat (300) @(posedge ref_clk);
    chk("irq masked", 16'h0000, {15'h0000, irq_q});
    rdc("flag", 4'h3, 8'h02);
  endtask : t_post
  // count frozen while stopped, control write keeps it
  task automatic t_stop();
    logic [7:0] v;
    wr(4'h1, 8'h00);
    wr(4'h2, 8'hff);
    wr(4'h0, 8'h04);
    repeat (40) @(posedge ref_clk);
    wr(4'h0, 8'h00);
    // raw read: the frozen count is only known once stopped
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= 4'h1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_q;
    chk("count ran", 16'h0001, {15'h0000, v != 8'h00});
    repeat (300) @(posedge ref_clk);
    wr(4'h0, 8'h7b);
    rdc("count", 4'h1, v);
  endtask : t_stop
  // =====================================================
  // main sequence and hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_pre();
    t_post();
    t_stop();
    end_sim();
  end
endmodule : tb_top
bind pmt_timer pmt_timer_properties #(.OSC_PER_INSTR(OSC_PER_INSTR)) u_chk (.ref_clk(ref_clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q), .match_q(match_q));
